// [rtl/pfs_pin_config.sv]
// Register bus slave and pin drive and routing outputs of the pin selector.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each port C sink bit picks its pin's sink level; zero at reset.
// - Port D sink register bits 7 to 2 are absent and read zero.
// - Port D sink bits 1 and 0 pick pin level; zero at reset.
// - Two 8-bit selects for ports A, B, C; port D has four bits.
// - Routing holds data, clock, receive bits and two timer fields; bit 7 absent.
// - A sink bit acts only while its pin is a push-pull output.
module pfs_pin_config import pfs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] portc_cmos_output,
    input wire logic [1:0] portd_cmos_output,
    output logic [7:0] portc_sink_strength,
    output logic portd_pin1_sink_level,
    output logic portd_pin0_sink_level,
    output logic [15:0] porta_output_function_select,
    output logic [15:0] portb_output_function_select,
    output logic [15:0] portc_output_function_select,
    output logic [3:0] portd_output_function_select,
    output logic twowire_data_pin_select,
    output logic twowire_clock_pin_select,
    output logic serial_receive_pin_select,
    output logic [1:0] periodic_timer_clock_pin_select,
    output logic [1:0] compact_timer_clock_pin_select
);

    // ------------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------------
    pfs_reg_if rif ();
    pfs_htrans_t trans;
    logic addr_take;
    logic addr_mapped;
    logic [3:0] addr_idx;
    logic wr_pend;
    logic [3:0] wr_idx_q;
    logic [7:0] next_rd_byte;

    assign trans = pfs_htrans_t'(htrans);
    assign addr_idx = haddr[5:2];
    assign addr_mapped = pfs_mapped(haddr);

    always_comb
    begin
        case (trans)
            PFS_TR_NONSEQ: addr_take = hsel && hready;
            PFS_TR_SEQ: addr_take = hsel && hready;
            default: addr_take = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Write data phase
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx_q <= 4'h0;
        end
        else if (addr_take)
        begin
            wr_pend <= hwrite && addr_mapped;
            wr_idx_q <= addr_idx;
        end
        else
        begin
            wr_pend <= 1'b0;
        end
    end

    assign rif.wr_en = wr_pend;
    assign rif.wr_idx = wr_idx_q;
    assign rif.wr_data = hwdata[7:0];

    pfs_regfile u_regfile
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .rif(rif)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // A read right behind a write to the same register sees the new value.
    always_comb
    begin
        next_rd_byte = 8'h00;
        if (addr_mapped)
        begin
            if (wr_pend && (wr_idx_q == addr_idx))
            begin
                next_rd_byte = hwdata[7:0] & pfs_wmask(addr_idx);
            end
            else
            begin
                next_rd_byte = rif.regs[addr_idx];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (addr_take && !hwrite)
        begin
            hrdata <= {24'h00_0000, next_rd_byte};
        end
        else
        begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sink strength drive
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            portc_sink_strength <= 8'h00;
            portd_pin1_sink_level <= 1'b0;
            portd_pin0_sink_level <= 1'b0;
        end
        else
        begin
            // A pin that is not a push-pull output keeps the minimum level.
            portc_sink_strength <= rif.regs[PFS_IDX_PORTC_SINK]
                & portc_cmos_output;
            portd_pin1_sink_level <= rif.regs[PFS_IDX_PORTD_SINK][1]
                & portd_cmos_output[1];
            portd_pin0_sink_level <= rif.regs[PFS_IDX_PORTD_SINK][0]
                & portd_cmos_output[0];
        end
    end

    // ------------------------------------------------------------------
    // Function selection and input routing
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            porta_output_function_select <= 16'h0000;
            portb_output_function_select <= 16'h0000;
            portc_output_function_select <= 16'h0000;
            portd_output_function_select <= 4'h0;
        end
        else
        begin
            porta_output_function_select <= {rif.regs[PFS_IDX_PA_HI],
                rif.regs[PFS_IDX_PA_LO]};
            portb_output_function_select <= {rif.regs[PFS_IDX_PB_HI],
                rif.regs[PFS_IDX_PB_LO]};
            portc_output_function_select <= {rif.regs[PFS_IDX_PC_HI],
                rif.regs[PFS_IDX_PC_LO]};
            portd_output_function_select <=
                rif.regs[PFS_IDX_PORTD_FSEL][3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            twowire_data_pin_select <= 1'b0;
            twowire_clock_pin_select <= 1'b0;
            serial_receive_pin_select <= 1'b0;
            periodic_timer_clock_pin_select <= 2'b00;
            compact_timer_clock_pin_select <= 2'b00;
        end
        else
        begin
            twowire_data_pin_select <=
                rif.regs[PFS_IDX_ROUTING][PFS_POS_TWOWIRE_DATA];
            twowire_clock_pin_select <=
                rif.regs[PFS_IDX_ROUTING][PFS_POS_TWOWIRE_CLOCK];
            serial_receive_pin_select <=
                rif.regs[PFS_IDX_ROUTING][PFS_POS_SERIAL_RX];
            periodic_timer_clock_pin_select <=
                rif.regs[PFS_IDX_ROUTING][PFS_POS_PTIMER_LSB +: 2];
            compact_timer_clock_pin_select <=
                rif.regs[PFS_IDX_ROUTING][PFS_POS_CTIMER_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    portc_sink_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PORTC_SINK)
        ##1 (portc_cmos_output == 8'hff)
        |=> (portc_sink_strength == $past(rif.wr_data, 2)))
    else $error("Port C sink level does not follow the written value.");

    portd_upper_zero_a: assert property (
        (addr_take && !hwrite && addr_mapped
            && addr_idx == PFS_IDX_PORTD_SINK)
        |=> (hrdata[31:2] == 30'h0000_0000))
    else $error("Port D sink read shows bits above bit 1.");

    portd_sink_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PORTD_SINK)
        ##1 (portd_cmos_output == 2'b11)
        |=> ({portd_pin1_sink_level, portd_pin0_sink_level}
            == $past(rif.wr_data[1:0], 2)))
    else $error("Port D sink levels do not follow the written value.");

    porta_fsel_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PA_HI)
        ##1 !(rif.wr_en && rif.wr_idx == PFS_IDX_PA_HI)
        |=> (porta_output_function_select[15:8] == $past(rif.wr_data, 2)))
    else $error("Port A high function select does not follow the write.");

    portd_fsel_width_a: assert property (
        (rif.regs[PFS_IDX_PORTD_FSEL][7:4] == 4'h0)
        && ($stable(portd_output_function_select)
        || $past(rif.wr_en, 2)))
    else $error("Port D function select holds or changes without cause.");

    routing_fields_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_ROUTING)
        ##1 !(rif.wr_en && rif.wr_idx == PFS_IDX_ROUTING)
        |=> ({twowire_data_pin_select, twowire_clock_pin_select,
            serial_receive_pin_select, periodic_timer_clock_pin_select,
            compact_timer_clock_pin_select} == $past(rif.wr_data[6:0], 2))
        && (rif.regs[PFS_IDX_ROUTING][7] == 1'b0))
    else $error("Input routing fields do not follow the write.");

    sink_gate_a: assert property (
        ((portc_sink_strength & ~$past(portc_cmos_output)) == 8'h00)
        && ({portd_pin1_sink_level, portd_pin0_sink_level}
            & ~$past(portd_cmos_output)) == 2'b00)
    else $error("Sink level raised on a pin that is not a push-pull output.");

    write_next_a: assert property (
        (rif.wr_en && rif.wr_idx <= PFS_LAST_IDX)
        |=> (rif.regs[$past(rif.wr_idx)]
            == ($past(rif.wr_data) & pfs_wmask($past(rif.wr_idx)))))
    else $error("Register write not visible on the next cycle.");

    porta_lo_fsel_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PA_LO)
        |=> ##1 (porta_output_function_select[7:0]
            == $past(rif.wr_data, 2)))
    else $error("Port A low function select does not follow the write.");

    portb_fsel_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PB_HI)
        |=> ##1 (portb_output_function_select[15:8]
            == $past(rif.wr_data, 2)))
    else $error("Port B high function select does not follow the write.");

    portc_fsel_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PC_LO)
        |=> ##1 (portc_output_function_select[7:0]
            == $past(rif.wr_data, 2)))
    else $error("Port C low function select does not follow the write.");

    portd_fsel_a: assert property (
        (rif.wr_en && rif.wr_idx == PFS_IDX_PORTD_FSEL)
        |=> ##1 (portd_output_function_select
            == $past(rif.wr_data[3:0], 2)))
    else $error("Port D function select does not follow the write.");

    portd_sink_store_a: assert property (
        rif.regs[PFS_IDX_PORTD_SINK][7:2] == 6'h00)
    else $error("Port D sink register holds bits above bit 1.");

    unmapped_write_a: assert property (
        (addr_take && hwrite && !addr_mapped) |=> !rif.wr_en)
    else $error("Write to an unmapped address reached the registers.");

    read_idle_a: assert property (
        !(addr_take && !hwrite) |=> (hrdata == 32'h0000_0000))
    else $error("Read data shown outside a read data phase.");

    unmapped_read_a: assert property (
        (addr_take && !hwrite && !addr_mapped) |=> (hrdata == 32'h0000_0000))
    else $error("Read of an unmapped address returned nonzero data.");

    cover_portc_write_c: cover property (
        rif.wr_en && rif.wr_idx == PFS_IDX_PORTC_SINK ##2
        portc_sink_strength != 8'h00);

    cover_portd_read_c: cover property (
        addr_take && !hwrite && addr_idx == PFS_IDX_PORTD_SINK);

    cover_write_read_c: cover property (
        wr_pend && addr_take && !hwrite && wr_idx_q == addr_idx);

    cover_routing_c: cover property (
        rif.wr_en && rif.wr_idx == PFS_IDX_ROUTING ##2
        twowire_data_pin_select);

    cover_sink_gated_c: cover property (
        (rif.regs[PFS_IDX_PORTC_SINK] != 8'h00) && (portc_cmos_output != 8'hff));

endmodule // pfs_pin_config
`default_nettype wire

// [rtl/pfs_pkg.sv]
// Constants, types and helpers shared by the pin function select block.
package pfs_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PFS_OFS_PORTC_SINK = 8'h00;
    localparam logic [7:0] PFS_OFS_PORTD_SINK = 8'h04;
    localparam logic [7:0] PFS_OFS_PORTA_FSEL_LO = 8'h08;
    localparam logic [7:0] PFS_OFS_PORTA_FSEL_HI = 8'h0c;
    localparam logic [7:0] PFS_OFS_PORTB_FSEL_LO = 8'h10;
    localparam logic [7:0] PFS_OFS_PORTB_FSEL_HI = 8'h14;
    localparam logic [7:0] PFS_OFS_PORTC_FSEL_LO = 8'h18;
    localparam logic [7:0] PFS_OFS_PORTC_FSEL_HI = 8'h1c;
    localparam logic [7:0] PFS_OFS_PORTD_FSEL = 8'h20;
    localparam logic [7:0] PFS_OFS_INPUT_ROUTING = 8'h24;

    // ------------------------------------------------------------------
    // Register indices, sizes, masks and reset values
    // ------------------------------------------------------------------
    localparam int PFS_NUM_REGS = 10;
    localparam logic [3:0] PFS_LAST_IDX = PFS_OFS_INPUT_ROUTING[5:2];
    localparam logic [3:0] PFS_IDX_PORTC_SINK = PFS_OFS_PORTC_SINK[5:2];
    localparam logic [3:0] PFS_IDX_PORTD_SINK = PFS_OFS_PORTD_SINK[5:2];
    localparam logic [3:0] PFS_IDX_PA_LO = PFS_OFS_PORTA_FSEL_LO[5:2];
    localparam logic [3:0] PFS_IDX_PA_HI = PFS_OFS_PORTA_FSEL_HI[5:2];
    localparam logic [3:0] PFS_IDX_PB_LO = PFS_OFS_PORTB_FSEL_LO[5:2];
    localparam logic [3:0] PFS_IDX_PB_HI = PFS_OFS_PORTB_FSEL_HI[5:2];
    localparam logic [3:0] PFS_IDX_PC_LO = PFS_OFS_PORTC_FSEL_LO[5:2];
    localparam logic [3:0] PFS_IDX_PC_HI = PFS_OFS_PORTC_FSEL_HI[5:2];
    localparam logic [3:0] PFS_IDX_PORTD_FSEL = PFS_OFS_PORTD_FSEL[5:2];
    localparam logic [3:0] PFS_IDX_ROUTING = PFS_OFS_INPUT_ROUTING[5:2];
    localparam logic [7:0] PFS_MASK_FULL = 8'hff;
    localparam logic [7:0] PFS_MASK_PORTD_SINK = 8'h03;
    localparam logic [7:0] PFS_MASK_PORTD_FSEL = 8'h0f;
    localparam logic [7:0] PFS_MASK_ROUTING = 8'h7f;
    localparam logic [7:0] PFS_RST_VAL = 8'h00;

    // ------------------------------------------------------------------
    // Input routing field positions
    // ------------------------------------------------------------------
    localparam int PFS_POS_TWOWIRE_DATA = 6;
    localparam int PFS_POS_TWOWIRE_CLOCK = 5;
    localparam int PFS_POS_SERIAL_RX = 4;
    localparam int PFS_POS_PTIMER_LSB = 2;
    localparam int PFS_POS_CTIMER_LSB = 0;

    typedef enum logic [1:0]
    {
        PFS_TR_IDLE = 2'b00,
        PFS_TR_BUSY = 2'b01,
        PFS_TR_NONSEQ = 2'b10,
        PFS_TR_SEQ = 2'b11
    } pfs_htrans_t;

    // Writable bits of the register at an index.
    function automatic logic [7:0] pfs_wmask(input logic [3:0] idx);
        case (idx)
            PFS_IDX_PORTD_SINK: pfs_wmask = PFS_MASK_PORTD_SINK;
            PFS_IDX_PORTD_FSEL: pfs_wmask = PFS_MASK_PORTD_FSEL;
            PFS_IDX_ROUTING: pfs_wmask = PFS_MASK_ROUTING;
            default: pfs_wmask = PFS_MASK_FULL;
        endcase
    endfunction

    // True when a bus address falls on one of the registers.
    function automatic logic pfs_mapped(input logic [31:0] addr);
        pfs_mapped = (addr[31:6] == 26'h0) && (addr[5:2] <= PFS_LAST_IDX);
    endfunction

endpackage

// [rtl/pfs_reg_if.sv]
// Write port and register contents between the bus slave and the store.
`timescale 1ns/1ps
`default_nettype none
interface pfs_reg_if import pfs_pkg::*; ();
    logic wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] regs [PFS_NUM_REGS];

    modport store
    (
        input wr_en,
        input wr_idx,
        input wr_data,
        output regs
    );

    modport user
    (
        output wr_en,
        output wr_idx,
        output wr_data,
        input regs
    );
endinterface
`default_nettype wire

// [rtl/pfs_regfile.sv]
// Flip-flop store of the configuration registers, addressed by index.
`timescale 1ns/1ps
`default_nettype none
module pfs_regfile import pfs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    pfs_reg_if.store rif
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < PFS_NUM_REGS; i++)
            begin
                rif.regs[i] <= PFS_RST_VAL;
            end
        end
        else if (rif.wr_en && (rif.wr_idx <= PFS_LAST_IDX))
        begin
            // Unimplemented bits are never stored, so they read as zero.
            rif.regs[rif.wr_idx] <= rif.wr_data & pfs_wmask(rif.wr_idx);
        end
    end

endmodule // pfs_regfile
`default_nettype wire

// [verification/pfs_tb.sv]
// Self-checking testbench for the pin function select block.
`timescale 1ns/1ps
`default_nettype none
module tb import pfs_pkg::*;;
    // ------------------------------------------------------------------
    // Signals and register table
    // ------------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pc_cmos, pc_sink;
    logic [1:0] pd_cmos, pt_sel, ct_sel;
    logic pd1, pd0, tw_data, tw_clk, rx_sel;
    logic [15:0] pa_sel, pb_sel, pc_sel;
    logic [3:0] pd_sel;
    logic [68:0] pins;
    int miscompares;
    int n_checks;
    localparam logic [7:0] OFS [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
        8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    localparam logic [7:0] WMASK [10] = '{8'hff, 8'h03, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h7f};
    localparam logic [7:0] PAT [10] = '{8'ha5, 8'h03, 8'h12, 8'h34, 8'h56,
        8'h78, 8'h9a, 8'hbc, 8'h0d, 8'h5b};

    assign hready = hreadyout;
    assign pins = {pc_sink, pd1, pd0, pa_sel, pb_sel, pc_sel, pd_sel,
        tw_data, tw_clk, rx_sel, pt_sel, ct_sel};

    pfs_pin_config uut
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .portc_cmos_output(pc_cmos),
        .portd_cmos_output(pd_cmos),
        .portc_sink_strength(pc_sink),
        .portd_pin1_sink_level(pd1),
        .portd_pin0_sink_level(pd0),
        .porta_output_function_select(pa_sel),
        .portb_output_function_select(pb_sel),
        .portc_output_function_select(pc_sel),
        .portd_output_function_select(pd_sel),
        .twowire_data_pin_select(tw_data),
        .twowire_clock_pin_select(tw_clk),
        .serial_receive_pin_select(rx_sel),
        .periodic_timer_clock_pin_select(pt_sel),
        .compact_timer_clock_pin_select(ct_sel)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [68:0] seen, input logic [68:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= PFS_TR_NONSEQ;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        htrans <= PFS_TR_IDLE;
        hsel <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        check({68'h0, hresp}, 69'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check({37'h0, r}, {61'h0, e});
    endtask

    task automatic pin_chk(input logic [68:0] e);
        #1;
        check(pins, e);
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        pin_chk(69'h0);
        for (int i = 0; i < 10; i++)
            rd_chk(OFS[i], 8'h00);
        $display("done reset values");
    endtask

    task automatic t_write_masks();
        for (int i = 0; i < 10; i++)
        begin
            wr(OFS[i], 8'hff);
            rd_chk(OFS[i], WMASK[i]);
        end
        for (int i = 0; i < 10; i++)
        begin
            wr(OFS[i], 8'h00);
            rd_chk(OFS[i], 8'h00);
        end
        $display("done write masks");
    endtask

    task automatic t_pin_outputs();
        for (int i = 0; i < 10; i++)
            wr(OFS[i], PAT[i]);
        pin_chk({8'ha5, 2'b11, 48'h3412_7856_bc9a, 4'hd, 7'h00});
        pin_chk({8'ha5, 2'b11, 48'h3412_7856_bc9a, 4'hd,
            3'b101, 2'b10, 2'b11});
        pc_cmos <= 8'h0f;
        pd_cmos <= 2'b10;
        @(posedge hclk);
        @(posedge hclk);
        pin_chk({8'h05, 2'b10, 48'h3412_7856_bc9a, 4'hd,
            3'b101, 2'b10, 2'b11});
        pc_cmos <= 8'h00;
        pd_cmos <= 2'b00;
        @(posedge hclk);
        @(posedge hclk);
        pin_chk({8'h00, 2'b00, 48'h3412_7856_bc9a, 4'hd,
            3'b101, 2'b10, 2'b11});
        pc_cmos <= 8'hff;
        pd_cmos <= 2'b11;
        $display("done pin outputs");
    endtask

    task automatic t_unmapped();
        wr(8'h28, 8'hff);
        wr(8'h40, 8'hff);
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h40, 8'h00);
        rd_chk(8'h3c, 8'h00);
        for (int i = 0; i < 10; i++)
            rd_chk(OFS[i], PAT[i] & WMASK[i]);
        $display("done unmapped");
    endtask

    task automatic t_mid_reset();
        hresetn <= 1'b0;
        @(posedge hclk);
        pin_chk(69'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values();
        $display("done mid reset");
    endtask

    task automatic t_shared_function();
        wr(PFS_OFS_INPUT_ROUTING, 8'h14);
        wr(PFS_OFS_PORTC_FSEL_LO, 8'h02);
        @(posedge hclk);
        pin_chk({8'h00, 2'b00, 48'h0000_0000_0002, 4'h0,
            3'b001, 2'b01, 2'b00});
        wr(PFS_OFS_PORTC_FSEL_LO, 8'h00);
        wr(PFS_OFS_INPUT_ROUTING, 8'h00);
        @(posedge hclk);
        pin_chk(69'h0);
        $display("done shared function");
    endtask

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial
    begin
        miscompares = 0;
        n_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = PFS_TR_IDLE;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        pc_cmos = 8'hff;
        pd_cmos = 2'b11;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values();
        t_write_masks();
        t_pin_outputs();
        t_unmapped();
        t_mid_reset();
        t_shared_function();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
